// *** acr_regs.vh ***
// constants for the adc serial configuration and readout block
`ifndef ACR_REGS_VH
`define ACR_REGS_VH
`define ACR_CFG_W        14
`define ACR_RES_W        16
`define ACR_CFG_UPD      13
`define ACR_INCC_HI      4'd12
`define ACR_INCC_LO      10
`define ACR_INCC_TEMP    3'b011
`define ACR_BW_BIT       6
`define ACR_REF_HI       4'd5
`define ACR_REF_LO       3
`define ACR_RB_BIT       0
`define ACR_CFG_RST      14'h3fff
`define ACR_RES_BITS     5'h0f
`define ACR_RES_BITS_BSY 5'h10
`define ACR_CONV_NS      2200
`define ACR_CONV_CYC     ((`ACR_CONV_NS + 19) / 20)
// wishbone byte offsets
`define ACR_A_CTRL       4'h0
`define ACR_A_CFG        4'h4
`define ACR_A_STAT       4'h8
`define ACR_A_RESULT     4'hc
`define ACR_CTRL_BUSY    0
`endif

// *** acr_sync.v ***
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module acr_sync (
  input  wire CLK,
  input  wire SRST,
  input  wire d,
  output reg  q
);
  reg meta;

  // meta is read only by q
  always @(posedge CLK) begin
    if (SRST) begin
      meta <= 1'b0;
      q    <= 1'b0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule // acr_sync

// *** acr_core.v ***
// adc serial port: config capture, result and readback shift, wishbone regs
`timescale 1ns/1ps
`include "acr_regs.vh"
module acr_core (
  input  wire        CLK,
  input  wire        SRST,
  input  wire        CONVERSION_TRIGGER,
  input  wire        SCK,
  input  wire        DIN,
  output reg         SERIAL_RESULT_OUT,
  output reg         BUSY_MODE,
  output reg  [2:0]  CHANNEL_SEL,
  output reg  [2:0]  INPUT_CFG,
  output reg         BW_QUARTER,
  output reg         REF_INT_EN,
  output reg         REF_4V096,
  output reg         TEMP_SENSOR_EN,
  output reg         REF_BUF_EN,
  output reg         LOW_POWER,
  output reg         CONVERTING,
  input  wire [3:0]  WB_ADR_I,
  input  wire [31:0] WB_DAT_I,
  output reg  [31:0] WB_DAT_O,
  input  wire        WB_WE_I,
  input  wire [3:0]  WB_SEL_I,
  input  wire        WB_CYC_I,
  input  wire        WB_STB_I,
  output reg         WB_ACK_O,
  output wire        WB_ERR_O
);
  wire        trig_s;
  wire        sck_s;
  wire        din_s;
  reg         trig_d;
  reg         sck_d;
  reg  [13:0] cfg_active;
  reg  [13:0] cfg_pending;
  reg         pend_valid;
  reg  [13:0] cfg_shift;
  reg  [4:0]  rise_cnt;
  reg  [5:0]  fall_cnt;
  reg  [29:0] out_shift;
  reg  [15:0] result;
  reg  [15:0] next_result;
  reg  [13:0] result_cfg;
  reg  [15:0] conv_cnt;
  reg  [1:0]  dummy_cnt;
  reg         busy_mode;
  reg  [15:0] sample_word;
  reg  [15:0] temp_word;
  reg  [1:0]  conv_state;
  wire        trig_rise;
  wire        sck_rise;
  wire        sck_fall;
  wire        wb_req;
  wire [4:0]  res_bits;
  wire [5:0]  total_bits;

  localparam ST_IDLE = 2'b00;
  localparam ST_CONV = 2'b01;
  localparam ST_DONE = 2'b10;

  // field decode used for both the temperature select and outputs
  function [2:0] acr_field;
    input [13:0] w;
    input [3:0]  hi;
    begin
      acr_field = {w[hi], w[hi-4'h1], w[hi-4'h2]};
    end
  endfunction

  acr_sync u_trig (.CLK(CLK), .SRST(SRST), .d(CONVERSION_TRIGGER),
                   .q(trig_s));
  acr_sync u_sck (.CLK(CLK), .SRST(SRST), .d(SCK), .q(sck_s));
  acr_sync u_din (.CLK(CLK), .SRST(SRST), .d(DIN), .q(din_s));

  // edge detection on synchronised pins only
  always @(posedge CLK) begin
    if (SRST) begin
      trig_d <= 1'b0;
      sck_d  <= 1'b0;
    end else begin
      trig_d <= trig_s;
      sck_d  <= sck_s;
    end
  end

  assign trig_rise = trig_s & ~trig_d;
  // serial clock only counts while the trigger line is low
  assign sck_rise  = sck_s & ~sck_d & ~trig_s;
  assign sck_fall  = ~sck_s & sck_d & ~trig_s;
  assign res_bits  = busy_mode ? `ACR_RES_BITS_BSY : `ACR_RES_BITS;
  // frame length: result bits, plus the word when readback is on
  assign total_bits = {1'b0, res_bits} +
                      (cfg_active[`ACR_RB_BIT] ? 6'd14 : 6'd0);

  // conversion timer: runs on trigger rise, frame timing not involved
  always @(posedge CLK) begin
    if (SRST) begin
      conv_state <= ST_IDLE;
      conv_cnt   <= 16'h0000;
      CONVERTING <= 1'b0;
      LOW_POWER  <= 1'b1;
    end else begin
      case (conv_state)
        ST_IDLE: begin
          if (trig_rise) begin
            conv_state <= ST_CONV;
            conv_cnt   <= 16'h0000;
            CONVERTING <= 1'b1;
            LOW_POWER  <= 1'b0;
          end
        end
        ST_CONV: begin
          conv_cnt <= conv_cnt + 16'h0001;
          if (conv_cnt == (`ACR_CONV_CYC - 1)) begin
            conv_state <= ST_DONE;
          end
        end
        ST_DONE: begin
          // power drops at end of each conversion phase
          CONVERTING <= 1'b0;
          LOW_POWER  <= 1'b1;
          conv_state <= ST_IDLE;
        end
        default: begin
          conv_state <= ST_IDLE;
        end
      endcase
    end
  end

  // digital stand-in for the converted value; temperature is plain binary
  always @* begin
    next_result = sample_word;
    if (acr_field(cfg_active, `ACR_INCC_HI) == `ACR_INCC_TEMP) begin
      next_result = temp_word;
    end
  end

  // end of conversion: latch result and apply pending config one frame late
  always @(posedge CLK) begin
    if (SRST) begin
      cfg_active <= `ACR_CFG_RST;
      result     <= 16'h0000;
      result_cfg <= `ACR_CFG_RST;
      dummy_cnt  <= 2'b00;
    end else if (conv_state == ST_DONE) begin
      result     <= next_result;
      result_cfg <= cfg_active;
      if (pend_valid) begin
        cfg_active <= cfg_pending;
      end
      if (dummy_cnt != 2'b10) begin
        dummy_cnt <= dummy_cnt + 2'b01;
      end
    end
  end

  // capture config on first 14 rising edges, msb first
  always @(posedge CLK) begin
    if (SRST) begin
      cfg_shift   <= 14'h0000;
      rise_cnt    <= 5'h00;
      cfg_pending <= `ACR_CFG_RST;
      pend_valid  <= 1'b0;
    end else begin
      // clear first, so a capture landing in the same cycle wins
      if (conv_state == ST_DONE) begin
        pend_valid <= 1'b0;
      end
      if (trig_rise) begin
        rise_cnt <= 5'h00;
      end else if (sck_rise && rise_cnt < 5'd14) begin
        cfg_shift <= {cfg_shift[12:0], din_s};
        rise_cnt  <= rise_cnt + 5'h01;
        if (rise_cnt == 5'd13 && cfg_shift[12] == 1'b1) begin
          // update bit set: overwrite, else keep current settings
          cfg_pending <= {cfg_shift[12:0], din_s};
          pend_valid  <= 1'b1;
        end
      end
    end
  end

  // busy mode follows last written wishbone control
  // result then config shifted out on falling edges, msb first
  always @(posedge CLK) begin
    if (SRST) begin
      fall_cnt          <= 6'h00;
      out_shift         <= 30'h00000000;
      SERIAL_RESULT_OUT <= 1'b0;
    end else if (trig_s) begin
      // frame start reloads: result followed by associated config
      fall_cnt  <= 6'h00;
      out_shift <= busy_mode ? {result, result_cfg}
                             : {result[15:1], result_cfg, 1'b0};
      SERIAL_RESULT_OUT <= 1'b0;
    end else if (sck_fall) begin
      if (fall_cnt < total_bits) begin
        SERIAL_RESULT_OUT <= out_shift[29];
        out_shift         <= {out_shift[28:0], 1'b0};
        fall_cnt          <= fall_cnt + 6'h01;
      end else begin
        SERIAL_RESULT_OUT <= 1'b0;
      end
    end
  end

  // configuration outputs decoded from the active word, BUSY_MODE from busy_mode
  always @(posedge CLK) begin
    if (SRST) begin
      CHANNEL_SEL    <= 3'b111;
      INPUT_CFG      <= 3'b111;
      BW_QUARTER     <= 1'b0;
      REF_INT_EN     <= 1'b0;
      REF_4V096      <= 1'b0;
      TEMP_SENSOR_EN <= 1'b0;
      REF_BUF_EN     <= 1'b1;
      BUSY_MODE      <= 1'b0;
    end else begin
      CHANNEL_SEL <= acr_field(cfg_active, 4'd9);
      INPUT_CFG   <= acr_field(cfg_active, `ACR_INCC_HI);
      BW_QUARTER  <= ~cfg_active[`ACR_BW_BIT];
      // ref field: 000 int 2.5, 001 int 4.096, 010 ext+sens, 110 ext no sens
      REF_INT_EN  <= ~cfg_active[`ACR_REF_HI] & ~cfg_active[4];
      REF_4V096   <= (acr_field(cfg_active, `ACR_REF_HI) ==
                      3'b001);
      TEMP_SENSOR_EN <= ~cfg_active[`ACR_REF_HI];
      REF_BUF_EN  <= (acr_field(cfg_active, `ACR_REF_HI) !=
                      3'b111);
      BUSY_MODE   <= busy_mode;
    end
  end

  // wishbone slave: single cycle ack, unmapped reads zero, err never raised
  assign wb_req   = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
  assign WB_ERR_O = 1'b0;

  always @(posedge CLK) begin
    if (SRST) begin
      WB_ACK_O    <= 1'b0;
      WB_DAT_O    <= 32'h00000000;
      busy_mode   <= 1'b0;
      sample_word <= 16'h0000;
      temp_word   <= 16'h0000;
    end else begin
      WB_ACK_O <= wb_req;
      if (wb_req && WB_WE_I) begin
        case (WB_ADR_I)
          `ACR_A_CTRL: begin
            if (WB_SEL_I[0]) busy_mode <= WB_DAT_I[`ACR_CTRL_BUSY];
          end
          `ACR_A_RESULT: begin
            if (WB_SEL_I[0]) sample_word[7:0]  <= WB_DAT_I[7:0];
            if (WB_SEL_I[1]) sample_word[15:8] <= WB_DAT_I[15:8];
            if (WB_SEL_I[2]) temp_word[7:0]    <= WB_DAT_I[23:16];
            if (WB_SEL_I[3]) temp_word[15:8]   <= WB_DAT_I[31:24];
          end
          default: begin
          end
        endcase
      end
      if (wb_req && !WB_WE_I) begin
        case (WB_ADR_I)
          `ACR_A_CTRL:   WB_DAT_O <= {31'h0, busy_mode};
          `ACR_A_CFG:    WB_DAT_O <= {2'b00, cfg_pending, 2'b00, cfg_active};
          `ACR_A_STAT:   WB_DAT_O <= {26'h0, dummy_cnt, pend_valid,
                                      LOW_POWER, CONVERTING, trig_s};
          `ACR_A_RESULT: WB_DAT_O <= {temp_word, result};
          default:       WB_DAT_O <= 32'h00000000;
        endcase
      end
    end
  end
endmodule // acr_core

// *** acr_core_chk.sv ***
// port assertions for the adc serial configuration and readout block
`timescale 1ns/1ps
module acr_core_chk (
  input wire CLK,
  input wire SRST,
  input wire CONVERSION_TRIGGER,
  input wire LOW_POWER,
  input wire CONVERTING,
  input wire REF_INT_EN,
  input wire TEMP_SENSOR_EN,
  input wire WB_CYC_I,
  input wire WB_STB_I,
  input wire WB_ACK_O,
  input wire WB_ERR_O
);
  logic [7:0] cnv_len;
  default clocking @(posedge CLK); endclocking
  default disable iff (SRST);
  // cycles spent converting, cleared while idle
  always @(posedge CLK) begin
    if (SRST || !CONVERTING) cnv_len <= 8'h00;
    else cnv_len <= cnv_len + 8'h01;
  end
  ack_one_cycle_a: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack held longer than one cycle");
  ack_has_cause_a: assert property ($rose(WB_ACK_O) |-> $past(WB_CYC_I && WB_STB_I))
    else $error("ack without a request");
  ack_prompt_a: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
    else $error("request not answered next cycle");
  err_quiet_a: assert property (!WB_ERR_O)
    else $error("error response raised");
  power_down_a: assert property (LOW_POWER != CONVERTING)
    else $error("low power not the inverse of converting");
  sensor_follows_a: assert property (REF_INT_EN |-> TEMP_SENSOR_EN)
    else $error("internal reference on without sensor");
  conv_starts_a: assert property ($rose(CONVERSION_TRIGGER) |-> ##[2:8] CONVERTING)
    else $error("trigger rise did not start a conversion");
  conv_length_a: assert property ($fell(CONVERTING) |-> cnv_len >= 8'd105 && cnv_len <= 8'd115)
    else $error("conversion length out of range");
  cover property ($fell(CONVERTING));
  cover property ($rose(TEMP_SENSOR_EN));
  cover property (WB_ACK_O && WB_CYC_I);
endmodule // acr_core_chk

// *** acr_host_model.sv ***
// serial host: starts conversions and runs framed transfers
`timescale 1ns/1ps
module acr_host_model (
  output logic trig,
  output logic sck,
  output logic din,
  input  wire  clk,
  input  wire  serial_result_out
);
  initial begin
    trig = 1'b0;
    sck = 1'b0;
    din = 1'b0;
  end
  // whole system clocks, then step off the edge to stay unrelated
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #7;
  endtask
  // sck idles low between bursts; 160 ns period inside the frame
  task automatic frame(input logic [13:0] cfg, input int n, output logic [31:0] got);
    got = 32'h0;
    for (int i = 0; i <= n; i++) begin
      din = (i < 14) ? cfg[13 - i] : 1'($urandom);
      tick(4);
      sck = 1'b1;
      tick(4);
      if (i > 0) got = {got[30:0], serial_result_out};
      sck = 1'b0;
    end
    din = ~din; // released line must not look like held data
  endtask
  // all port activity ends before the trigger rises
  task automatic convert;
    tick(4);
    trig = 1'b1;
    tick(130);
    trig = 1'b0;
    tick(4);
  endtask
endmodule // acr_host_model

// *** acr_core_test.sv ***
// self-checking bench for the adc serial configuration and readout block
`timescale 1ns/1ps
`include "acr_regs.vh"
module acr_core_test;
  logic        clk, srst, cyc, stb, we, serial_result_out, trig, sck, din, ack, err;
  logic        busy_mode, ref_int, tsens, ref_4v, ref_buf, bwq, lp, conv;
  logic [2:0]  chan, incfg, inx, prev;
  logic [3:0]  adr;
  logic [13:0] c;
  logic [15:0] r, tw;
  logic [31:0] wdat, rdat, got;
  logic [31:0] exp_q[$];
  int          err_total = 0;
  int          n_checks = 0;
  event        frame_ev;
  acr_core acr_core_i (.CLK(clk), .SRST(srst), .CONVERSION_TRIGGER(trig),
    .SCK(sck), .DIN(din), .SERIAL_RESULT_OUT(serial_result_out), .BUSY_MODE(busy_mode),
    .CHANNEL_SEL(chan), .INPUT_CFG(incfg), .BW_QUARTER(bwq),
    .REF_INT_EN(ref_int), .REF_4V096(ref_4v), .TEMP_SENSOR_EN(tsens),
    .REF_BUF_EN(ref_buf), .LOW_POWER(lp), .CONVERTING(conv),
    .WB_ADR_I(adr), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_WE_I(we),
    .WB_SEL_I(4'hf), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_ACK_O(ack),
    .WB_ERR_O(err));
  acr_host_model acr_host_model_i (.clk(clk), .trig(trig), .sck(sck),
    .din(din), .serial_result_out(serial_result_out));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    n_checks++;
    if (seen !== want) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task automatic stop_test;
    if (err_total == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // one classic cycle, held until ack is sampled, bounded wait
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && k < 20);
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1) begin
      err_total++;
      stop_test();
    end
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    wb(1'b0, a, 32'h0);
  endtask
  // read answers and frame results meet the oldest note
  always @(posedge clk) begin
    if (ack === 1'b1 && we === 1'b0) check(rdat, exp_q.pop_front());
  end
  always @(frame_ev) check(got, exp_q.pop_front());
  initial begin
    srst = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 4'h0;
    wdat = 32'h0;
    prev = 3'b111;
    void'($urandom(76));
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    rd(`ACR_A_STAT, 32'h4);
    rd(4'h2, 32'h0); // unmapped offset reads zero
    // every reference code; two dummy rounds before trusting the word
    for (int rf = 0; rf < 8; rf++) begin
      r = 16'($urandom);
      inx = 3'($urandom);
      c = {1'b1, 3'b111, inx, 1'b0, 3'(rf), 2'b00, 1'b1};
      wb(1'b1, `ACR_A_RESULT, {16'h0, r});
      acr_host_model_i.frame(c, 14, got);
      check(32'(chan), 32'(prev));
      acr_host_model_i.convert();
      acr_host_model_i.frame(c, 14, got);
      acr_host_model_i.convert();
      exp_q.push_back({3'h0, r[15:1], c});
      acr_host_model_i.frame(c, 29, got);
      -> frame_ev;
      check(32'(chan), 32'(inx));
      check(32'(incfg), 32'h7);
      check(32'(ref_int), 32'(rf < 2));
      check(32'(ref_4v), 32'(rf == 1));
      check(32'(tsens), 32'(rf < 4));
      check(32'(ref_buf), 32'(rf != 7));
      check(32'(bwq), 32'h1);
      // counters only restart on a trigger pulse, so close the frame
      acr_host_model_i.convert();
      prev = inx;
    end
    // word with its update bit clear must leave settings alone
    repeat (2) begin
      acr_host_model_i.frame({1'b0, c[12:10], ~inx, c[6:0]}, 14, got);
      acr_host_model_i.convert();
    end
    check(32'(chan), 32'(inx));
    // busy mode: sixteen result bits, then the word
    wb(1'b1, `ACR_A_CTRL, 32'h1);
    rd(`ACR_A_CTRL, 32'h1);
    acr_host_model_i.frame(c, 14, got);
    acr_host_model_i.convert();
    exp_q.push_back({2'h0, r, c});
    acr_host_model_i.frame(c, 30, got);
    -> frame_ev;
    check(32'(busy_mode), 32'h1);
    // temperature input with the internal reference kept active
    tw = 16'($urandom);
    c = {1'b1, `ACR_INCC_TEMP, inx, 1'b0, 3'b000, 2'b00, 1'b1};
    wb(1'b1, `ACR_A_RESULT, {tw, r});
    acr_host_model_i.convert();
    repeat (2) begin
      acr_host_model_i.frame(c, 14, got);
      acr_host_model_i.convert();
    end
    exp_q.push_back({2'h0, tw, c});
    acr_host_model_i.frame(c, 30, got);
    -> frame_ev;
    check(32'(incfg), 32'h3);
    check(32'(ref_int), 32'h1);
    check(32'(tsens), 32'h1);
    rd(`ACR_A_RESULT, {tw, tw});
    stop_test();
  end
endmodule // acr_core_test
bind acr_core acr_core_chk acr_core_chk_i (.CLK(CLK), .SRST(SRST),
  .CONVERSION_TRIGGER(CONVERSION_TRIGGER), .LOW_POWER(LOW_POWER),
  .CONVERTING(CONVERTING), .REF_INT_EN(REF_INT_EN),
  .TEMP_SENSOR_EN(TEMP_SENSOR_EN), .WB_CYC_I(WB_CYC_I),
  .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O), .WB_ERR_O(WB_ERR_O));
